//--- bench/test_wdt_fault_reset.sv
// self-checking bench for the watchdog and stack-fault reset control block
`timescale 1ns/1ns
module test_wdt_fault_reset;
   import wdt_fault_pkg::*;

   // ==========================================================
   // signals
   // short periods keep the run brief, expectations follow these values
   localparam int unsigned SHORT_N = 8;
   localparam int unsigned LONG_N  = 16;
   logic              pclk;
   logic              presetn;
   logic              psel;
   logic              penable;
   logic              pwrite;
   logic [ADDR_W-1:0] paddr;
   logic [31:0]       pwdata;
   logic [31:0]       prdata;
   logic              pready;
   logic              pslverr;
   logic              instr_exec;
   logic              int_stack_fault;
   logic              addr_stack_fault;
   logic [2:0]        interrupt_stack_level;
   logic [1:0]        data_buffer_stack_level;
   logic              ce_pin_rise;
   logic              ce_timer_carry;
   logic [3:0]        call_stack_pointer;
   logic              fault_reset_pulse;
   logic              ce_reset_pulse;
   logic [32:0]       exp_q[$];
   int                err_count;
   int                total_checks;
   int                fault_seen;
   int                ce_seen;
   logic [7:0]        rnd;

   wdt_fault_reset #(.WDT_SHORT_COUNT(SHORT_N), .WDT_LONG_COUNT(LONG_N)) wdt_fault_reset_i
   (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .instr_exec(instr_exec), .int_stack_fault(int_stack_fault), .addr_stack_fault(addr_stack_fault),
      .interrupt_stack_level(interrupt_stack_level), .data_buffer_stack_level(data_buffer_stack_level),
      .ce_pin_rise(ce_pin_rise), .ce_timer_carry(ce_timer_carry), .call_stack_pointer(call_stack_pointer),
      .fault_reset_pulse(fault_reset_pulse), .ce_reset_pulse(ce_reset_pulse)
   );

   initial
   begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end

   // ==========================================================
   // helpers
   function automatic logic [7:0] lfsr_next(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : lfsr_next

   task automatic end_sim();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : end_sim

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask : check

   task automatic apb(input logic w, input logic [7:0] a, input logic [3:0] d, input logic [3:0] e,
                      input logic err);
      int n;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= {28'h000_0000, d};
      exp_q.push_back({err, 28'h000_0000, e});
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      n = 1;
      while (pready !== 1'b1 && n < 20)
      begin
         @(posedge pclk);
         n++;
      end
      if (n >= 20)
      begin
         err_count++;
         end_sim();
      end
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [3:0] d);
      apb(1'b1, a, d, 4'h0, 1'b0);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [3:0] e);
      apb(1'b0, a, 4'h0, e, 1'b0);
   endtask : rd

   // which: 0 instruction, 1 interrupt stack fault, 2 address stack fault, 3 ce rise, 4 carry
   task automatic pulse(input int which, input int n);
      repeat (n)
      begin
         @(posedge pclk);
         case (which)
            0: instr_exec <= 1'b1;
            1: int_stack_fault <= 1'b1;
            2: addr_stack_fault <= 1'b1;
            3: ce_pin_rise <= 1'b1;
            default: ce_timer_carry <= 1'b1;
         endcase
         @(posedge pclk);
         {instr_exec, int_stack_fault, addr_stack_fault, ce_pin_rise, ce_timer_carry} <= 5'h00;
      end
      repeat (3) @(posedge pclk);
   endtask : pulse

   // ==========================================================
   // monitor: takes the oldest note when an access completes
   always @(posedge pclk)
   begin
      if (fault_reset_pulse === 1'b1)
         fault_seen++;
      if (ce_reset_pulse === 1'b1)
         ce_seen++;
      if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1)
      begin
         if (exp_q.size() == 0)
            check(32'hffff_ffff, 32'h0000_0000);
         else
         begin
            check({31'h0000_0000, pslverr}, {31'h0000_0000, exp_q[0][32]});
            if (pwrite === 1'b0)
               check(prdata, exp_q[0][31:0]);
            void'(exp_q.pop_front());
         end
      end
   end

   // ==========================================================
   // main sequence
   initial
   begin
      {psel, penable, pwrite, instr_exec, int_stack_fault, addr_stack_fault} = 6'h00;
      {ce_pin_rise, ce_timer_carry} = 2'h0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      interrupt_stack_level = 3'h5;
      data_buffer_stack_level = 2'h2;
      err_count = 0;
      total_checks = 0;
      fault_seen = 0;
      ce_seen = 0;
      rnd = 8'h21;
      presetn = 1'b0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      rd(8'h04, 4'hf);
      rd(8'h08, 4'h3);
      rd(8'h14, 4'h3);
      rd(8'h18, 4'h2);
      rd(8'h58, 4'h0);
      rd(8'h0c, 4'h0);
      rd(8'h10, 4'h2);
      rd(8'h20, 4'h5);
      wr(8'h20, 4'h1);
      rd(8'h20, 4'h5);
      apb(1'b0, 8'h1c, 4'h0, 4'h0, 1'b1);
      apb(1'b1, 8'h05, 4'h1, 4'h0, 1'b1);
      wr(8'h04, 4'h5);
      // the write lands at the access edge, so look once it has settled
      @(negedge pclk);
      check(32'(call_stack_pointer), 32'h0000_0005);
      // power-on period code selects the long count
      pulse(0, LONG_N - 1);
      check(32'(fault_seen), 32'h0000_0000);
      pulse(0, 1);
      check(32'(fault_seen), 32'h0000_0001);
      check(32'(call_stack_pointer), 32'h0000_000f);
      rd(8'h58, 4'h1);
      rd(8'h58, 4'h0);
      // first write locks the period, the second is dropped
      wr(8'h08, 4'h1);
      wr(8'h08, 4'h3);
      rd(8'h08, 4'h1);
      pulse(0, SHORT_N - 1);
      wr(8'h0c, 4'h0);
      pulse(0, 1);
      check(32'(fault_seen), 32'h0000_0002);
      pulse(0, SHORT_N - 1);
      wr(8'h0c, 4'h8);
      pulse(0, SHORT_N - 1);
      check(32'(fault_seen), 32'h0000_0002);
      pulse(0, 1);
      check(32'(fault_seen), 32'h0000_0003);
      wr(8'h14, 4'h1);
      wr(8'h14, 4'h2);
      rd(8'h14, 4'h1);
      pulse(1, 1);
      check(32'(fault_seen), 32'h0000_0003);
      pulse(2, 1);
      check(32'(fault_seen), 32'h0000_0004);
      for (int n = 2; n <= 4; n++)
      begin
         wr(8'h04, 4'h6);
         wr(8'h18, 4'(n));
         rd(8'h18, 4'(n));
         pulse(3, 1);
         pulse(4, n - 1);
         check(32'(ce_seen), 32'(n - 2));
         pulse(4, 1);
         check(32'(ce_seen), 32'(n - 1));
         check(32'(call_stack_pointer), 32'h0000_000f);
      end
      rd(8'h58, 4'h1);
      rd(8'h58, 4'h0);
      for (int i = 0; i < 6; i++)
      begin
         rnd = lfsr_next(rnd);
         interrupt_stack_level <= rnd[6:4];
         data_buffer_stack_level <= rnd[1:0];
         wr(8'h04, rnd[3:0]);
         rd(8'h04, rnd[3:0]);
         check(32'(call_stack_pointer), 32'(rnd[3:0]));
         rd(8'h20, {1'b0, rnd[6:4]});
         rd(8'h10, {2'h0, rnd[1:0]});
      end
      // a second power-on clears the flag and the lock; the unused code leaves the watchdog idle
      presetn <= 1'b0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      rd(8'h58, 4'h0);
      wr(8'h08, 4'h0);
      rd(8'h08, 4'h0);
      pulse(0, LONG_N + 1);
      check(32'(fault_seen), 32'h0000_0004);
      repeat (4) @(posedge pclk);
      end_sim();
   end

endmodule : test_wdt_fault_reset

//--- rtl/event_counter.sv
// clearable up-counter advanced by a one-cycle increment pulse
`timescale 1ns/1ns
module event_counter
#(
   parameter int unsigned WIDTH = 4
)
(
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             clear,
   input  wire logic             inc,
   output logic [WIDTH-1:0]      count
);

   logic [WIDTH-1:0] count_ff;
   logic [WIDTH-1:0] nxt_count;

   initial
   begin
      if (WIDTH < 1)
      begin
         $error("event_counter: WIDTH must be at least 1");
      end
   end

   // clear wins over a simultaneous increment
   always_comb
   begin
      nxt_count = count_ff;
      if (clear)
      begin
         nxt_count = '0;
      end
      else if (inc)
      begin
         nxt_count = count_ff + WIDTH'(1);
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         count_ff <= '0;
      end
      else
      begin
         count_ff <= nxt_count;
      end
   end

   assign count = count_ff;

endmodule : event_counter

//--- rtl/wdt_fault_pkg.sv
// constants for the watchdog and stack-fault reset control block
package wdt_fault_pkg;

   // ==========================================================
   // register indices, byte address is four times the index
   localparam int unsigned ADDR_W            = 8;
   localparam logic [5:0]  IDX_CALL_SP       = 6'h01;
   localparam logic [5:0]  IDX_WDT_PERIOD    = 6'h02;
   localparam logic [5:0]  IDX_WDT_CLEAR     = 6'h03;
   localparam logic [5:0]  IDX_DBF_LEVEL     = 6'h04;
   localparam logic [5:0]  IDX_STACK_SEL     = 6'h05;
   localparam logic [5:0]  IDX_CE_CARRY      = 6'h06;
   localparam logic [5:0]  IDX_INT_LEVEL     = 6'h08;
   localparam logic [5:0]  IDX_FAULT_STATUS  = 6'h16;

   // ==========================================================
   // values after power-on reset
   localparam logic [3:0]  RST_CALL_SP       = 4'hf;
   localparam logic [1:0]  RST_WDT_PERIOD    = 2'h3;
   localparam logic [1:0]  RST_STACK_SEL     = 2'h3;
   localparam logic [3:0]  RST_CE_CARRY      = 4'h2;

   // ==========================================================
   // field positions
   localparam int unsigned POS_WDT_CLEAR     = 3;
   localparam int unsigned POS_SEL_INT_STACK = 1;
   localparam int unsigned POS_SEL_ADR_STACK = 0;
   localparam int unsigned POS_FAULT_FLAG    = 0;

   // ==========================================================
   // watchdog period codes
   typedef enum logic [1:0]
   {
      WDT_UNUSED     = 2'h0,
      WDT_SHORT      = 2'h1,
      WDT_PROHIBITED = 2'h2,
      WDT_LONG       = 2'h3
   } wdt_period_t;

   localparam int unsigned WDT_PERIOD_SHORT  = 65536;
   localparam int unsigned WDT_PERIOD_LONG   = 131072;

endpackage : wdt_fault_pkg

//--- rtl/wdt_fault_reset.sv
// watchdog, stack-fault reset selection and chip-enable reset carry count
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ns
module wdt_fault_reset
   import wdt_fault_pkg::*;
#(
   parameter int unsigned WDT_SHORT_COUNT = WDT_PERIOD_SHORT,
   parameter int unsigned WDT_LONG_COUNT  = WDT_PERIOD_LONG,
   parameter int unsigned CE_CNT_W        = 4
)
(
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic              instr_exec,
   input  wire logic              int_stack_fault,
   input  wire logic              addr_stack_fault,
   input  wire logic [2:0]        interrupt_stack_level,
   input  wire logic [1:0]        data_buffer_stack_level,
   input  wire logic              ce_pin_rise,
   input  wire logic              ce_timer_carry,
   output logic [3:0]             call_stack_pointer,
   output logic                   fault_reset_pulse,
   output logic                   ce_reset_pulse
);

   localparam int unsigned WDT_W = $clog2(WDT_LONG_COUNT);
   localparam logic [WDT_W-1:0] WDT_LAST_SHORT = WDT_W'(WDT_SHORT_COUNT - 1);
   localparam logic [WDT_W-1:0] WDT_LAST_LONG  = WDT_W'(WDT_LONG_COUNT - 1);

   initial
   begin
      if (WDT_SHORT_COUNT < 2 || WDT_SHORT_COUNT > WDT_LONG_COUNT || CE_CNT_W != 4)
      begin
         $error("wdt_fault_reset: unsupported parameter values");
      end
   end

   // ==========================================================
   // bus decode
   logic [5:0]  idx;
   logic        mapped;
   logic        setup_rd;
   logic        acc_done;
   logic        wr_en;

   assign idx = paddr[ADDR_W-1:2];

   always_comb
   begin
      mapped = 1'b0;
      case (idx)
         IDX_CALL_SP, IDX_WDT_PERIOD, IDX_WDT_CLEAR, IDX_DBF_LEVEL,
         IDX_STACK_SEL, IDX_CE_CARRY, IDX_INT_LEVEL, IDX_FAULT_STATUS:
            mapped = (paddr[1:0] == 2'b00);
         default:
            mapped = 1'b0;
      endcase
   end

   // read data is latched in the setup cycle so the access phase needs no wait
   assign setup_rd = psel & ~penable & ~pwrite;
   assign acc_done = psel & penable;
   assign wr_en    = acc_done & pwrite & mapped;
   assign pready   = 1'b1;
   assign pslverr  = acc_done & ~mapped;

   // ==========================================================
   // register state
   logic [3:0]  call_sp_ff,     nxt_call_sp;
   logic [1:0]  period_ff,      nxt_period;
   logic        period_lock_ff, nxt_period_lock;
   logic [1:0]  stack_sel_ff,   nxt_stack_sel;
   logic        sel_lock_ff,    nxt_sel_lock;
   logic [3:0]  ce_carry_ff,    nxt_ce_carry;
   logic        flag_ff,        nxt_flag;
   logic        flag_read_ff,   nxt_flag_read;
   logic [31:0] prdata_ff,      nxt_prdata;
   logic        fault_ff,       nxt_fault;
   logic        ce_rst_ff,      nxt_ce_rst;
   logic        ce_arm_ff,      nxt_ce_arm;

   logic             wd_clear_wr;
   logic             wd_enabled;
   logic [WDT_W-1:0] wd_last;
   logic [WDT_W-1:0] wd_count;
   logic             wd_expire;
   logic             stack_fault;
   logic [3:0]       ce_count;
   logic [3:0]       ce_target;
   logic             ce_done;

   assign wd_clear_wr = wr_en & (idx == IDX_WDT_CLEAR) & pwdata[POS_WDT_CLEAR];

   // unused and prohibited codes leave the watchdog idle rather than guessing a period
   always_comb
   begin
      wd_enabled = 1'b1;
      wd_last    = WDT_LAST_LONG;
      case (wdt_period_t'(period_ff))
         WDT_SHORT:
            wd_last = WDT_LAST_SHORT;
         WDT_LONG:
            wd_last = WDT_LAST_LONG;
         default:
            wd_enabled = 1'b0;
      endcase
   end

   assign wd_expire   = wd_enabled & instr_exec & (wd_count == wd_last) & ~wd_clear_wr;
   assign stack_fault = (int_stack_fault  & stack_sel_ff[POS_SEL_INT_STACK]) |
                        (addr_stack_fault & stack_sel_ff[POS_SEL_ADR_STACK]);

   // a setting of zero or one means a single carry
   assign ce_target = (ce_carry_ff < 4'h2) ? 4'h1 : ce_carry_ff;
   assign ce_done   = ce_arm_ff & ce_timer_carry & ((ce_count + 4'h1) >= ce_target);

   event_counter #(.WIDTH(WDT_W)) u_wdt_count
   (
      .pclk    (pclk),
      .presetn (presetn),
      .clear   (wd_clear_wr | fault_ff | ce_rst_ff | wd_expire),
      .inc     (instr_exec & wd_enabled),
      .count   (wd_count)
   );

   event_counter #(.WIDTH(4)) u_ce_count
   (
      .pclk    (pclk),
      .presetn (presetn),
      .clear   (ce_pin_rise | ce_done | ~ce_arm_ff),
      .inc     (ce_arm_ff & ce_timer_carry),
      .count   (ce_count)
   );

   // ==========================================================
   // next-state
   always_comb
   begin
      nxt_call_sp     = call_sp_ff;
      nxt_period      = period_ff;
      nxt_period_lock = period_lock_ff;
      nxt_stack_sel   = stack_sel_ff;
      nxt_sel_lock    = sel_lock_ff;
      nxt_ce_carry    = ce_carry_ff;
      nxt_prdata      = prdata_ff;
      nxt_flag_read   = flag_read_ff;
      nxt_fault       = wd_expire | stack_fault;
      nxt_ce_rst      = ce_done;
      nxt_ce_arm      = ce_arm_ff;

      if (wr_en)
      begin
         case (idx)
            IDX_CALL_SP:
               nxt_call_sp = pwdata[3:0];
            IDX_WDT_PERIOD:
            begin
               if (!period_lock_ff)
               begin
                  nxt_period      = pwdata[1:0];
                  nxt_period_lock = 1'b1;
               end
            end
            IDX_STACK_SEL:
            begin
               if (!sel_lock_ff)
               begin
                  nxt_stack_sel = pwdata[1:0];
                  nxt_sel_lock  = 1'b1;
               end
            end
            IDX_CE_CARRY:
               nxt_ce_carry = pwdata[3:0];
            default:
               nxt_call_sp = call_sp_ff;
         endcase
      end

      if (ce_pin_rise)
      begin
         nxt_ce_arm = 1'b1;
      end
      if (ce_done)
      begin
         nxt_ce_arm = 1'b0;
      end

      // both internal resets put the call stack back to empty
      if (fault_ff | ce_rst_ff)
      begin
         nxt_call_sp = RST_CALL_SP;
      end

      if (setup_rd)
      begin
         nxt_flag_read = 1'b0;
         case (idx)
            IDX_CALL_SP:      nxt_prdata = {28'h000_0000, call_sp_ff};
            IDX_WDT_PERIOD:   nxt_prdata = {30'h0000_0000, period_ff};
            IDX_DBF_LEVEL:    nxt_prdata = {30'h0000_0000, data_buffer_stack_level};
            IDX_STACK_SEL:    nxt_prdata = {30'h0000_0000, stack_sel_ff};
            IDX_CE_CARRY:     nxt_prdata = {28'h000_0000, ce_carry_ff};
            IDX_INT_LEVEL:    nxt_prdata = {29'h0000_0000, interrupt_stack_level};
            IDX_FAULT_STATUS:
            begin
               nxt_prdata    = {31'h0000_0000, flag_ff};
               nxt_flag_read = flag_ff;
            end
            default:          nxt_prdata = 32'h0000_0000;
         endcase
      end

      // only a one that was actually returned is cleared, and a new fault wins
      nxt_flag = fault_ff | (flag_ff & ~(acc_done & ~pwrite & (idx == IDX_FAULT_STATUS) & flag_read_ff));
   end

   // ==========================================================
   // registers, power-on reset only; CE reset leaves flag and locks alone
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         call_sp_ff     <= RST_CALL_SP;
         period_ff      <= RST_WDT_PERIOD;
         period_lock_ff <= 1'b0;
         stack_sel_ff   <= RST_STACK_SEL;
         sel_lock_ff    <= 1'b0;
         ce_carry_ff    <= RST_CE_CARRY;
         flag_ff        <= 1'b0;
         flag_read_ff   <= 1'b0;
         prdata_ff      <= 32'h0000_0000;
         fault_ff       <= 1'b0;
         ce_rst_ff      <= 1'b0;
         ce_arm_ff      <= 1'b0;
      end
      else
      begin
         call_sp_ff     <= nxt_call_sp;
         period_ff      <= nxt_period;
         period_lock_ff <= nxt_period_lock;
         stack_sel_ff   <= nxt_stack_sel;
         sel_lock_ff    <= nxt_sel_lock;
         ce_carry_ff    <= nxt_ce_carry;
         flag_ff        <= nxt_flag;
         flag_read_ff   <= nxt_flag_read;
         prdata_ff      <= nxt_prdata;
         fault_ff       <= nxt_fault;
         ce_rst_ff      <= nxt_ce_rst;
         ce_arm_ff      <= nxt_ce_arm;
      end
   end

   assign prdata             = prdata_ff;
   assign call_stack_pointer = call_sp_ff;
   assign fault_reset_pulse  = fault_ff;
   assign ce_reset_pulse     = ce_rst_ff;

   // ==========================================================
   // assertions
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_period_write_once: assert property (
      (period_lock_ff && wr_en && idx == IDX_WDT_PERIOD) |=> $stable(period_ff))
      else $error("watchdog period changed after its single write");

   a_stack_fault_reset: assert property (
      (int_stack_fault && stack_sel_ff[POS_SEL_INT_STACK]) |=> fault_reset_pulse ##1 call_stack_pointer == RST_CALL_SP)
      else $error("selected interrupt stack fault gave no reset");

   a_clear_restarts_count: assert property (
      (wd_clear_wr && !stack_fault) |=> (wd_count == '0) && !fault_reset_pulse)
      else $error("watchdog clear did not restart the count");

   a_flag_after_fault: assert property (
      fault_reset_pulse |=> flag_ff [*2])
      else $error("fault flag not set after a fault reset");

   a_flag_read_clears: assert property (
      (setup_rd && idx == IDX_FAULT_STATUS && flag_ff ##1 acc_done && !pwrite && !fault_ff) |=> !flag_ff)
      else $error("fault flag not cleared by its read");

   a_ce_carry_count: assert property (
      (ce_arm_ff && ce_timer_carry && ce_carry_ff == 4'h3 && ce_count == 4'h2) |=> ce_reset_pulse ##1 !ce_reset_pulse)
      else $error("chip-enable reset not taken at the third carry");

   a_wdt_expiry_reset: assert property (
      (wdt_period_t'(period_ff) == WDT_SHORT && instr_exec && wd_count == WDT_LAST_SHORT && !wd_clear_wr)
      |=> fault_reset_pulse ##1 (wd_count == '0))
      else $error("watchdog expiry did not request a reset");

   a_unmapped_error: assert property (
      (acc_done && !mapped) |-> pslverr && pready)
      else $error("unmapped access not flagged");

endmodule : wdt_fault_reset
